/* File: rtl/interlock_diag_defines.vh */
// constants for the interlock diagnostic and indication logic
// assumes a 40 MHz core clock
`ifndef INTERLOCK_DIAG_DEFINES_VH
`define INTERLOCK_DIAG_DEFINES_VH
`define CLK_HZ 40000000
// flash timing in milliseconds
`define FLASH_ON_MS 250
`define FLASH_OFF_MS 250
`define FLASH_PAUSE_MS 1500
// warning timeout in minutes
`define WARN_TIMEOUT_MIN 30
// one tick per millisecond
`define MS_CYCLES (`CLK_HZ / 1000)
`define WARN_TIMEOUT_MS (`WARN_TIMEOUT_MIN * 60 * 1000)
// flash codes
`define CODE_NONE 3'h0
`define CODE_OUT1 3'h1
`define CODE_OUT2 3'h2
`define CODE_CROSS 3'h3
`define CODE_TEMP 3'h4
`define CODE_ACT 3'h5
`define CODE_COMBO 3'h6
`define CODE_STEADY 3'h7
`endif

/* File: rtl/flash_coder.v */
// red lamp flash-group generator
// assumes a one-cycle millisecond tick from the same clock
`timescale 1ns/1ps
`include "interlock_diag_defines.vh"
module flash_coder (
  input wire core_clk_i,
  input wire reset_i,
  input wire ms_tick_i,
  input wire [2:0] code_i,
  output reg lamp_o
);
  reg [10:0] ms_q;
  reg [2:0] cnt_q;
  reg phase_q;
  reg pause_q;
  wire [10:0] limit;
  assign limit = pause_q ? 11'd`FLASH_PAUSE_MS :
                 (phase_q ? 11'd`FLASH_ON_MS : 11'd`FLASH_OFF_MS);
  always @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      ms_q <= 11'h000;
      cnt_q <= 3'h0;
      phase_q <= 1'b0;
      pause_q <= 1'b1;
      lamp_o <= 1'b0;
    end else if (code_i == `CODE_NONE) begin
      ms_q <= 11'h000;
      cnt_q <= 3'h0;
      phase_q <= 1'b0;
      pause_q <= 1'b1;
      lamp_o <= 1'b0;
    end else if (code_i == `CODE_STEADY) begin
      lamp_o <= 1'b1;
      pause_q <= 1'b1;
    end else if (ms_tick_i) begin
      if (ms_q + 11'd1 >= limit) begin
        ms_q <= 11'h000;
        if (pause_q) begin
          pause_q <= 1'b0;
          phase_q <= 1'b1;
          cnt_q <= 3'h1;
          lamp_o <= 1'b1;
        end else if (phase_q) begin
          phase_q <= 1'b0;
          lamp_o <= 1'b0;
        end else if (cnt_q >= code_i) begin
          pause_q <= 1'b1;
        end else begin
          phase_q <= 1'b1;
          cnt_q <= cnt_q + 3'h1;
          lamp_o <= 1'b1;
        end
      end else begin
        ms_q <= ms_q + 11'd1;
      end
    end
  end
endmodule // flash_coder

/* File: rtl/interlock_diag_indicator.v */
// lamp, diagnostic output and fault state machine of the interlock
// assumes fault detectors and door sensors are asynchronous pins
`timescale 1ns/1ps
`include "interlock_diag_defines.vh"
module interlock_diag_indicator #(
  parameter POWER_TO_UNLOCK = 1,
  parameter [26:0] WARN_TIMEOUT_MS = `WARN_TIMEOUT_MS
) (
  input wire core_clk_i,
  input wire reset_i,
  input wire lock_ctrl_i,
  input wire door_closed_i,
  input wire actuator_ok_i,
  input wire bolt_locked_i,
  input wire fault_out1_i,
  input wire fault_out2_i,
  input wire fault_cross_i,
  input wire temp_high_i,
  input wire actuator_bad_i,
  input wire actuator_combo_i,
  input wire internal_fault_i,
  input wire supply_bad_i,
  output reg first_safety_output_o,
  output reg second_safety_output_o,
  output reg diag_out_o,
  output reg solenoid_unlock_o,
  output reg lamp_green_o,
  output reg lamp_yellow_o,
  output wire lamp_red_o
);
  localparam NIN = 12;
  localparam [3:0] ST_RUN = 4'h1;
  localparam [3:0] ST_WARN = 4'h2;
  localparam [3:0] ST_ERROR = 4'h4;
  localparam [3:0] ST_LOCKOUT = 4'h8;
  wire [NIN-1:0] raw;
  reg [NIN-1:0] s1_q;
  reg [NIN-1:0] s2_q;
  reg [3:0] state_q;
  reg [3:0] state_d;
  reg [2:0] code_q;
  reg [2:0] code_d;
  reg [26:0] warn_ms_q;
  reg [15:0] div_q;
  reg ms_tick_q;
  reg door_seen_open_q;
  reg [1:0] blink_q;
  reg [8:0] blink_ms_q;
  wire lock_in, door, act_ok, bolt, f1, f2, fx, th, ab, ac, fi, fs;
  wire warn_any, err_now, lock_now, timed_out;
  reg [2:0] warn_code;
  reg [2:0] err_code;
  assign raw = {supply_bad_i, internal_fault_i, actuator_combo_i,
                actuator_bad_i, temp_high_i, fault_cross_i, fault_out2_i,
                fault_out1_i, bolt_locked_i, actuator_ok_i, door_closed_i,
                lock_ctrl_i};
  // pins pass two flops per bit
  genvar g;
  generate
    for (g = 0; g < NIN; g = g + 1) begin : sync
      always @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
          s1_q[g] <= 1'b0;
          s2_q[g] <= 1'b0;
        end else begin
          s1_q[g] <= raw[g];
          s2_q[g] <= s1_q[g];
        end
      end
    end
  endgenerate
  assign {fs, fi, ac, ab, th, fx, f2, f1, bolt, act_ok, door, lock_in} = s2_q;
  assign warn_any = f1 | f2 | fx | th;
  assign lock_now = fx | (f1 & f2);
  assign err_now = ab | ac | fi | fs;
  assign timed_out = (warn_ms_q >= WARN_TIMEOUT_MS);
  always @* begin
    warn_code = `CODE_NONE;
    if (fx | (f1 & f2))
      warn_code = `CODE_CROSS;
    else if (f1)
      warn_code = `CODE_OUT1;
    else if (f2)
      warn_code = `CODE_OUT2;
    else if (th)
      warn_code = `CODE_TEMP;
  end
  always @* begin
    err_code = `CODE_NONE;
    if (fi | fs)
      err_code = `CODE_STEADY;
    else if (ac)
      err_code = `CODE_COMBO;
    else if (ab)
      err_code = `CODE_ACT;
  end
  // millisecond enable; the 30 min count stays small this way
  always @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      div_q <= 16'h0000;
      ms_tick_q <= 1'b0;
    end else if (div_q == `MS_CYCLES - 1) begin
      div_q <= 16'h0000;
      ms_tick_q <= 1'b1;
    end else begin
      div_q <= div_q + 16'h0001;
      ms_tick_q <= 1'b0;
    end
  end
  always @* begin
    state_d = state_q;
    code_d = code_q;
    case (state_q)
      ST_RUN: begin
        if (err_now) begin
          state_d = ST_ERROR;
          code_d = err_code;
        end else if (warn_any) begin
          state_d = ST_WARN;
          code_d = warn_code;
        end
      end
      ST_WARN: begin
        code_d = warn_code;
        if (err_now) begin
          state_d = ST_ERROR;
          code_d = err_code;
        end else if (!warn_any) begin
          state_d = ST_RUN;
          code_d = `CODE_NONE;
        end else if (timed_out) begin
          state_d = lock_now ? ST_LOCKOUT : ST_ERROR;
        end
      end
      ST_ERROR: begin
        if (err_now && err_code > code_q)
          code_d = err_code;
        if (!err_now && !warn_any && door_seen_open_q && door) begin
          state_d = ST_RUN;
          code_d = `CODE_NONE;
        end
      end
      ST_LOCKOUT: begin
        state_d = ST_LOCKOUT;
        if (err_now && err_code > code_q)
          code_d = err_code;
      end
      default: begin
        state_d = ST_ERROR;
        code_d = `CODE_STEADY;
      end
    endcase
  end
  always @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_q <= ST_RUN;
      code_q <= `CODE_NONE;
      warn_ms_q <= 27'h0000000;
      door_seen_open_q <= 1'b0;
    end else begin
      state_q <= state_d;
      code_q <= code_d;
      if (state_q != ST_WARN)
        warn_ms_q <= 27'h0000000;
      else if (ms_tick_q && !timed_out)
        warn_ms_q <= warn_ms_q + 27'h0000001;
      // opening counts only once cause gone
      if (state_q != ST_ERROR)
        door_seen_open_q <= 1'b0;
      else if (!door && !err_now && !warn_any)
        door_seen_open_q <= 1'b1;
    end
  end
  // yellow blinks when actuator in but not locked
  always @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      blink_ms_q <= 9'h000;
      blink_q <= 2'h0;
    end else if (ms_tick_q) begin
      if (blink_ms_q == 9'd499) begin
        blink_ms_q <= 9'h000;
        blink_q <= blink_q + 2'h1;
      end else begin
        blink_ms_q <= blink_ms_q + 9'h001;
      end
    end
  end
  always @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      first_safety_output_o <= 1'b0;
      second_safety_output_o <= 1'b0;
      diag_out_o <= 1'b0;
      solenoid_unlock_o <= 1'b0;
      lamp_green_o <= 1'b0;
      lamp_yellow_o <= 1'b0;
    end else begin
      solenoid_unlock_o <= (POWER_TO_UNLOCK != 0) ? lock_in : !lock_in;
      lamp_green_o <= 1'b1;
      if (state_q == ST_RUN || state_q == ST_WARN)
        lamp_yellow_o <= door & act_ok & (bolt | blink_q[0]);
      else
        lamp_yellow_o <= 1'b0;
      first_safety_output_o <= (state_q == ST_RUN || state_q == ST_WARN) &
                               door & act_ok & bolt;
      second_safety_output_o <= (state_q == ST_RUN || state_q == ST_WARN) &
                                door & act_ok & bolt;
      diag_out_o <= (state_q == ST_RUN) & door & act_ok &
                    (bolt | !lock_in);
    end
  end
  flash_coder u_flash (
    .core_clk_i(core_clk_i),
    .reset_i(reset_i),
    .ms_tick_i(ms_tick_q),
    .code_i(code_q),
    .lamp_o(lamp_red_o)
  );
endmodule // interlock_diag_indicator

/* File: dv/plc_model.sv */
// controller model that drives the lock request pin
// assumes requests come from the bench just after rising edges
`timescale 1ns/1ps
module plc_model (
  input wire core_clk_i,
  input wire unlock_req_i,
  input wire diag_i,
  output wire diag_view_o,
  output reg lock_ctrl_o
);
  reg diag_seen_q = 1'b0;
  initial lock_ctrl_o = 1'b0;
  always @(posedge core_clk_i) diag_seen_q <= #2 diag_i;
  // shown only, never feeds the lock request
  assign diag_view_o = diag_seen_q;
  // level request, moved just after the edge
  always @(posedge core_clk_i) lock_ctrl_o <= #2 unlock_req_i;
endmodule // plc_model

/* File: dv/interlock_diag_chk.sv */
// assertion checker for the interlock indicator ports
// assumes one clock domain; lock polarity follows the bound instance
`timescale 1ns/1ps
module interlock_diag_chk #(
  parameter POWER_TO_UNLOCK = 1
) (
  input wire core_clk_i,
  input wire reset_i,
  input wire lock_ctrl_i,
  input wire door_closed_i,
  input wire actuator_ok_i,
  input wire bolt_locked_i,
  input wire fault_out1_i,
  input wire fault_out2_i,
  input wire temp_high_i,
  input wire actuator_bad_i,
  input wire actuator_combo_i,
  input wire internal_fault_i,
  input wire supply_bad_i,
  input wire first_safety_output_o,
  input wire second_safety_output_o,
  input wire diag_out_o,
  input wire solenoid_unlock_o,
  input wire lamp_green_o,
  input wire lamp_yellow_o,
  input wire lamp_red_o
);
  wire err = actuator_bad_i | actuator_combo_i | internal_fault_i |
    supply_bad_i;
  // cross short left out: it may end in lockout
  wire warn = fault_out1_i | fault_out2_i | temp_high_i;
  wire ok = door_closed_i & actuator_ok_i & bolt_locked_i & ~err;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (reset_i);
  unlock_rise_a: assert property (
    $rose(lock_ctrl_i) ##0 lock_ctrl_i [*5] |->
    solenoid_unlock_o == (POWER_TO_UNLOCK != 0))
    else $error("solenoid wrong for high lock input");
  unlock_fall_a: assert property (
    $fell(lock_ctrl_i) ##0 !lock_ctrl_i [*5] |->
    solenoid_unlock_o == (POWER_TO_UNLOCK == 0))
    else $error("solenoid wrong for low lock input");
  steady_red_a: assert property (
    (internal_fault_i | supply_bad_i) [*5] |-> lamp_red_o)
    else $error("red lamp not steady on internal fault");
  error_shutdown_a: assert property (
    err [*5] |-> !first_safety_output_o && !second_safety_output_o)
    else $error("safety outputs on during error");
  warn_diag_off_a: assert property (
    warn [*5] |-> !diag_out_o)
    else $error("diag high during warning");
  warn_keeps_on_a: assert property (
    ($rose(warn) && first_safety_output_o) ##1 (warn && ok) [*5]
    |-> first_safety_output_o)
    else $error("warning dropped safety output");
  green_power_a: assert property (
    !$past(reset_i) |-> lamp_green_o)
    else $error("green lamp off with supply");
  error_yellow_a: assert property (
    err [*6] |-> !lamp_yellow_o)
    else $error("yellow lamp on during error");
  outputs_paired_a: assert property (
    first_safety_output_o == second_safety_output_o)
    else $error("safety outputs disagree");
  door_open_off_a: assert property (
    !door_closed_i [*5] |-> !first_safety_output_o)
    else $error("safety output on with door open");
endmodule // interlock_diag_chk

bind interlock_diag_indicator interlock_diag_chk
  #(.POWER_TO_UNLOCK(POWER_TO_UNLOCK)) interlock_diag_chk_inst (.*);

/* File: dv/interlock_diag_indicator_tb_top.sv */
// self-checking bench for the interlock indicator
// assumes partner model and checker are compiled first
`timescale 1ns/1ps
module interlock_diag_indicator_tb_top;
  reg core_clk_i = 1'b0;
  reg reset_i = 1'b1;
  reg unlock_req = 1'b0;
  reg door = 1'b1;
  reg act = 1'b1;
  reg bolt = 1'b1;
  reg [7:0] flt = 8'h00;
  wire lock_ctrl, s1, s2, diag, sol, grn, yel, red;
  wire sol2, view;
  integer mismatches = 0;
  integer cmp_count = 0;
  integer i, n;
  always #12.5 core_clk_i = ~core_clk_i;
  plc_model plc_model_inst (.core_clk_i(core_clk_i),
    .unlock_req_i(unlock_req), .diag_i(diag), .diag_view_o(view),
    .lock_ctrl_o(lock_ctrl));
  // one ms timeout keeps the lockout run short
  interlock_diag_indicator #(.WARN_TIMEOUT_MS(27'h1))
    interlock_diag_indicator_inst (.core_clk_i(core_clk_i),
    .reset_i(reset_i), .lock_ctrl_i(lock_ctrl), .door_closed_i(door),
    .actuator_ok_i(act), .bolt_locked_i(bolt), .fault_out1_i(flt[0]),
    .fault_out2_i(flt[1]), .fault_cross_i(flt[2]), .temp_high_i(flt[3]),
    .actuator_bad_i(flt[4]), .actuator_combo_i(flt[5]),
    .internal_fault_i(flt[6]), .supply_bad_i(flt[7]),
    .first_safety_output_o(s1), .second_safety_output_o(s2),
    .diag_out_o(diag), .solenoid_unlock_o(sol), .lamp_green_o(grn),
    .lamp_yellow_o(yel), .lamp_red_o(red));
  // second copy in the power to lock variant, same stimulus
  interlock_diag_indicator #(.POWER_TO_UNLOCK(0), .WARN_TIMEOUT_MS(27'h1))
    interlock_diag_indicator_p2l_inst (.core_clk_i(core_clk_i),
    .reset_i(reset_i), .lock_ctrl_i(lock_ctrl), .door_closed_i(door),
    .actuator_ok_i(act), .bolt_locked_i(bolt), .fault_out1_i(flt[0]),
    .fault_out2_i(flt[1]), .fault_cross_i(flt[2]), .temp_high_i(flt[3]),
    .actuator_bad_i(flt[4]), .actuator_combo_i(flt[5]),
    .internal_fault_i(flt[6]), .supply_bad_i(flt[7]),
    .first_safety_output_o(), .second_safety_output_o(),
    .diag_out_o(), .solenoid_unlock_o(sol2), .lamp_green_o(),
    .lamp_yellow_o(), .lamp_red_o());
  task chk(input string what, input exp, input got);
    begin
      cmp_count = cmp_count + 1;
      if (got !== exp) begin
        mismatches = mismatches + 1;
        $display("mismatch %s expected %b seen %b", what, exp, got);
      end
    end
  endtask
  task cyc(input integer k);
    begin
      repeat (k) @(posedge core_clk_i);
      #2;
    end
  endtask
  task door_cycle;
    begin
      door = 1'b0;
      cyc(8);
      door = 1'b1;
      cyc(8);
    end
  endtask
  task t_run;
    begin
      chk("green", 1'b1, grn);
      chk("yellow", 1'b1, yel);
      chk("red", 1'b0, red);
      chk("out1", 1'b1, s1);
      chk("diag", 1'b1, diag);
      chk("plc view", 1'b1, view);
    end
  endtask
  task t_lock;
    begin
      chk("p2l idle", 1'b1, sol2);
      unlock_req = 1'b1;
      cyc(8);
      chk("unlock", 1'b1, sol);
      chk("p2l lock", 1'b0, sol2);
      unlock_req = 1'b0;
      cyc(8);
      chk("lock", 1'b0, sol);
      chk("p2l unlock", 1'b1, sol2);
    end
  endtask
  task t_warn;
    begin
      for (i = 0; i < 4; i = i + 1) if (i != 2) begin
        flt = 8'h01 << i;
        cyc(6);
        chk("warn diag", 1'b0, diag);
        chk("warn out1", 1'b1, s1);
        chk("warn out2", 1'b1, s2);
        flt = 8'h00;
        cyc(6);
        chk("warn clear", 1'b1, diag);
      end
    end
  endtask
  task t_err;
    begin
      for (i = 4; i < 8; i = i + 1) begin
        flt = 8'h01 << i;
        cyc(6);
        chk("err out1", 1'b0, s1);
        chk("err out2", 1'b0, s2);
        chk("err diag", 1'b0, diag);
        if (i >= 6)
          chk("err red", 1'b1, red);
        flt = 8'h00;
        cyc(6);
        chk("err held", 1'b0, s1);
        door_cycle;
        chk("err clear", 1'b1, s1);
        chk("clear red", 1'b0, red);
      end
    end
  endtask
  task t_lockout;
    begin
      flt = 8'h04;
      n = 0;
      while (s1 === 1'b1 && n < 50000) begin
        cyc(1);
        n = n + 1;
      end
      chk("timeout", 1'b0, s1);
      chk("lock diag", 1'b0, diag);
      chk("timeout out2", 1'b0, s2);
      flt = 8'h00;
      door_cycle;
      chk("lockout held", 1'b0, s1);
      reset_i = 1'b1;
      cyc(2);
      reset_i = 1'b0;
      cyc(10);
      chk("power cycle", 1'b1, s1);
      chk("power cycle out2", 1'b1, s2);
    end
  endtask
  task wrap_up;
    begin
      if (mismatches == 0 && cmp_count > 0)
        $display("[ PASS ]");
      else
        $display("[ FAIL ]");
      $finish;
    end
  endtask
  initial begin
    #(25 * 60000);
    mismatches = mismatches + 1;
    wrap_up;
  end
  initial begin
    cyc(16);
    reset_i = 1'b0;
    cyc(10);
    t_run;
    t_lock;
    t_warn;
    t_err;
    t_lockout;
    wrap_up;
  end
endmodule // interlock_diag_indicator_tb_top
